// ===== rtl/irq_latch_ctrl.sv
// Interrupt latches, enable flags and acceptance sequencing
//
// Contract
// R1: Twenty-one sources besides reset; five levels shared by two selectable sources.
// R2: Software, undefined-opcode, address-trap and watchdog are non-maskable; rest maskable.
// R3: A source request sets its latch; enabled latches ask the CPU.
// R4: Simultaneous pending requests are taken in fixed priority; nesting allowed.
// R5: Non-maskable sources share one rank; only reset ranks above. Code ranks level 1 over trap 2 over watchdog 3.
// R6: Software/undefined use FFFC; trap FFFA on bit 2; watchdog FFF8 on bit 3.
// R7: Maskable level needs master flag and its own enable flag both set.
// R8: External 0: latch bit 4, vector FFF6, also needs pin enable.
// R9: Level 8 takes time base on select 0, external 2 on 1.
// R10: Level 9 timer1/external3; levels 13, 14 serial1/ext4, receiver/ext5 likewise.
// R11: Level 15 takes converter on select 0, serial 2 on 1.
// R12: Software clears trap output select to get trap interrupts.
// R13: Software clears watchdog output select to get watchdog interrupts.
// R14: Every source has a latch except software and undefined-opcode.
// R15: Accepted level's latch clears at once; reset clears all latches.
// R16: Latches read at 3C/3D; writing 0 clears, writing 1 never sets.
// R17: Software never clears bits 2, 3; writes them as 1.
// R18: Software clears latches only with plain loads.
// R19: Main program drops master flag around enable or latch changes.
// R20: Acceptance clears the master flag automatically.
// R21: Non-maskable sources are taken regardless of any enable flag.
// R22: Enable register at 3A/3B, fully readable and writable; low-byte bits 1-3 here read 0 and ignore writes.
// R23: Master flag is bit 0 of low enable byte, resets 0, saved and restored.
// R24: Acceptance lasts eight machine cycles after the current instruction.
// R25: At each boundary the best pending enabled level's vector goes out.
`timescale 1ns/1ps
module irq_latch_ctrl (
  input wire logic ref_clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic clk_en_i, // Freezes all state while low
  input wire logic [7:0] sfr_addr_i, // Register address
  input wire logic sfr_wr_i, // Register write strobe
  input wire logic sfr_rd_i, // Register read strobe
  input wire logic [7:0] sfr_wdata_i, // Register write data
  output logic [7:0] sfr_rdata_o, // Register read data, next cycle
  input wire logic [4:0] shared_level_selector_i, // Shared level source selects
  input wire logic ext0_pin_enable_i, // External 0 pin function enable
  input wire logic trap_output_select_i, // 1: address trap goes to reset
  input wire logic watchdog_output_select_i, // 1: watchdog goes to reset
  input wire logic software_trap_source_i, // Software trap at boundary
  input wire logic undefined_opcode_source_i, // Undefined opcode at boundary
  input wire logic address_trap_source_i, // Address trap event
  input wire logic watchdog_source_i, // Watchdog event
  input wire logic external_request_0_i, // External request 0
  input wire logic external_request_1_i, // External request 1
  input wire logic external_request_2_i, // External request 2
  input wire logic external_request_3_i, // External request 3
  input wire logic external_request_4_i, // External request 4
  input wire logic external_request_5_i, // External request 5
  input wire logic timer4_source_i, // Timer 4 event
  input wire logic timer5_source_i, // Timer 5 event
  input wire logic time_base_source_i, // Time base event
  input wire logic timer1_source_i, // Timer 1 event
  input wire logic timer3_source_i, // Timer 3 event
  input wire logic timer6_source_i, // Timer 6 event
  input wire logic timer2_source_i, // Timer 2 event
  input wire logic serial1_source_i, // Serial 1 event
  input wire logic receiver_source_i, // Receiver event
  input wire logic converter_source_i, // Converter event
  input wire logic serial2_source_i, // Serial 2 event
  input wire logic boundary_i, // CPU at an instruction boundary
  input wire logic return_from_interrupt_i, // Return restores master flag
  input wire logic restore_master_i, // Stacked master flag value
  output logic int_request_o, // Acceptable request pending
  output logic accepting_o, // Acceptance sequence running
  output logic accept_done_o, // Last cycle of acceptance
  output logic [15:0] vector_o, // Vector of the accepted level
  output logic saved_master_o, // Master flag before acceptance
  output logic trap_reset_request_o // Trap or watchdog routed to reset
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [15:0] request_latch;
  logic [15:0] enable_register;
  irq_ctrl_pkg::accept_state_e state;
  logic [5:0] cycle_count;

  logic [15:0] raw_request;
  logic [15:0] clear_mask;
  logic [15:0] next_request_latch;
  logic [15:0] next_enable_register;
  logic soft_request;
  logic master_enable_flag;
  logic [15:0] level_enable_flag;
  logic take;

  irq_pick_if pick ();

  irq_priority_pick u_pick (
    .pick(pick.picker)
  );

  assign master_enable_flag = enable_register[irq_ctrl_pkg::MASTER_BIT];
  assign level_enable_flag = enable_register & irq_ctrl_pkg::MASKABLE_MASK;
  assign soft_request = software_trap_source_i | undefined_opcode_source_i; // R14

  // ----------------------------------------
  // Source routing
  // ----------------------------------------
  always_comb begin
    raw_request = 16'h0000;
    raw_request[2] = address_trap_source_i & ~trap_output_select_i; // R12
    raw_request[3] = watchdog_source_i & ~watchdog_output_select_i; // R13
    raw_request[4] = external_request_0_i;
    raw_request[5] = external_request_1_i;
    raw_request[6] = timer4_source_i;
    raw_request[7] = timer5_source_i;
    raw_request[8] = shared_level_selector_i[irq_ctrl_pkg::SEL_LEVEL8] ?
        external_request_2_i : time_base_source_i; // R9
    raw_request[9] = shared_level_selector_i[irq_ctrl_pkg::SEL_LEVEL9] ?
        external_request_3_i : timer1_source_i; // R10
    raw_request[10] = timer3_source_i;
    raw_request[11] = timer6_source_i;
    raw_request[12] = timer2_source_i;
    raw_request[13] = shared_level_selector_i[irq_ctrl_pkg::SEL_LEVEL13] ?
        external_request_4_i : serial1_source_i; // R10
    raw_request[14] = shared_level_selector_i[irq_ctrl_pkg::SEL_LEVEL14] ?
        external_request_5_i : receiver_source_i; // R10
    raw_request[15] = shared_level_selector_i[irq_ctrl_pkg::SEL_LEVEL15] ?
        serial2_source_i : converter_source_i; // R11
  end // R1

  // ----------------------------------------
  // Pending levels for the picker
  // ----------------------------------------
  always_comb begin
    pick.pending = 16'h0000;
    pick.pending[irq_ctrl_pkg::LEVEL_SOFT] = soft_request; // R6
    pick.pending[irq_ctrl_pkg::LEVEL_TRAP] = request_latch[2]; // R21
    pick.pending[irq_ctrl_pkg::LEVEL_WATCHDOG] = request_latch[3]; // R21
    // Maskable levels need both flags
    pick.pending = pick.pending |
        (request_latch & level_enable_flag & {16{master_enable_flag}}); // R7
    // External 0 is also gated by its pin function
    pick.pending[irq_ctrl_pkg::LEVEL_EXT0] = pick.pending[irq_ctrl_pkg::LEVEL_EXT0] &
        ext0_pin_enable_i; // R8
  end // R2 R5

  assign take = (state == irq_ctrl_pkg::ST_IDLE) && boundary_i && pick.found; // R25
  assign int_request_o = (state == irq_ctrl_pkg::ST_IDLE) && pick.found; // R3
  assign accepting_o = (state == irq_ctrl_pkg::ST_ACCEPT);
  assign accept_done_o = clk_en_i && (state == irq_ctrl_pkg::ST_ACCEPT) &&
      (cycle_count == 6'h00);

  // ----------------------------------------
  // Request latches
  // ----------------------------------------
  always_comb begin
    clear_mask = 16'h0000;
    if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_LOW) begin
      clear_mask[7:0] = ~sfr_wdata_i & irq_ctrl_pkg::LATCH_LOW_MASK; // R16
    end else if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_HIGH) begin
      clear_mask[15:8] = ~sfr_wdata_i; // R16
    end
    if (take && pick.level >= irq_ctrl_pkg::LEVEL_TRAP) begin
      clear_mask = clear_mask | (16'h0001 << pick.level); // R15
    end
    // A request in the clearing cycle survives the clear
    next_request_latch = ((request_latch & ~clear_mask) | raw_request) &
        irq_ctrl_pkg::LATCH_MASK; // R3 R18
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      request_latch <= irq_ctrl_pkg::LATCH_RESET; // R15
    end else if (clk_en_i) begin
      request_latch <= next_request_latch;
    end
  end

  // ----------------------------------------
  // Enable register
  // ----------------------------------------
  always_comb begin
    next_enable_register = enable_register;
    if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_LOW) begin
      next_enable_register[7:0] = sfr_wdata_i & irq_ctrl_pkg::ENABLE_LOW_MASK; // R22
    end else if (sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_HIGH) begin
      next_enable_register[15:8] = sfr_wdata_i; // R22
    end
    // Acceptance beats a software write to the master flag
    if (take) begin
      next_enable_register[irq_ctrl_pkg::MASTER_BIT] = 1'b0; // R20
    end else if (return_from_interrupt_i) begin
      next_enable_register[irq_ctrl_pkg::MASTER_BIT] = restore_master_i; // R23
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      enable_register <= irq_ctrl_pkg::ENABLE_RESET; // R23
    end else if (clk_en_i) begin
      enable_register <= next_enable_register;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sfr_rdata_o <= irq_ctrl_pkg::READ_IDLE;
    end else if (clk_en_i && sfr_rd_i) begin
      if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_LOW) begin
        sfr_rdata_o <= enable_register[7:0]; // R22
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_ENABLE_HIGH) begin
        sfr_rdata_o <= enable_register[15:8]; // R22
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_LOW) begin
        sfr_rdata_o <= request_latch[7:0]; // R16
      end else if (sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_HIGH) begin
        sfr_rdata_o <= request_latch[15:8]; // R16
      end else begin
        sfr_rdata_o <= irq_ctrl_pkg::READ_IDLE;
      end
    end
  end

  // ----------------------------------------
  // Acceptance sequence
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= irq_ctrl_pkg::ST_IDLE;
      cycle_count <= 6'h00;
    end else if (clk_en_i) begin
      case (state)
        irq_ctrl_pkg::ST_IDLE: begin
          if (take) begin
            state <= irq_ctrl_pkg::ST_ACCEPT; // R4
            cycle_count <= irq_ctrl_pkg::ACCEPT_LOAD; // R24
          end
        end
        irq_ctrl_pkg::ST_ACCEPT: begin
          if (cycle_count == 6'h00) begin
            state <= irq_ctrl_pkg::ST_IDLE;
          end else begin
            cycle_count <= cycle_count - 6'h01; // R24
          end
        end
        default: begin
          state <= irq_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      vector_o <= irq_ctrl_pkg::VECTOR_RESET;
      saved_master_o <= 1'b0;
    end else if (clk_en_i && take) begin
      vector_o <= pick.vector; // R6 R25
      saved_master_o <= master_enable_flag; // R23
    end
  end

  // Routed-to-reset events never touch a latch
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      trap_reset_request_o <= 1'b0;
    end else if (clk_en_i) begin
      trap_reset_request_o <= (address_trap_source_i & trap_output_select_i) |
          (watchdog_source_i & watchdog_output_select_i);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_LATCH_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R3
      clk_en_i |=> ((request_latch & $past(raw_request)) == $past(raw_request)))
    else $error("request did not set its latch");

  AST_WRITE_NO_SET: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
      (clk_en_i && raw_request == 16'h0000 && !take) |=>
      ((request_latch & ~$past(request_latch)) == 16'h0000))
    else $error("latch rose without a request");

  AST_WRITE_CLEARS: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
      (clk_en_i && sfr_wr_i && sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_HIGH &&
      !take && raw_request == 16'h0000) |=>
      (request_latch[15:8] == ($past(request_latch[15:8]) & $past(sfr_wdata_i))))
    else $error("zero write did not clear latch");

  AST_READ_LATCH: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R16
      (clk_en_i && sfr_rd_i && sfr_addr_i == irq_ctrl_pkg::ADDR_LATCH_LOW) |=>
      (sfr_rdata_o == $past(request_latch[7:0])))
    else $error("latch read returned wrong data");

  AST_ACCEPT_IMF: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R20
      (clk_en_i && take) |=> (!master_enable_flag &&
      saved_master_o == $past(master_enable_flag)))
    else $error("acceptance did not clear and save master flag");

  AST_RFI_RESTORE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R23
      (clk_en_i && return_from_interrupt_i && !take) |=>
      (master_enable_flag == $past(restore_master_i)))
    else $error("return did not restore master flag");

  AST_ACCEPT_CLEARS_LATCH: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R15
      (clk_en_i && take && pick.level >= irq_ctrl_pkg::LEVEL_TRAP &&
      raw_request[pick.level] == 1'b0) |=> !request_latch[$past(pick.level)])
    else $error("accepted latch not cleared");

  AST_VECTOR: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R6
      (clk_en_i && take) |=> (vector_o == irq_ctrl_pkg::vector_of($past(pick.level))
      && accepting_o))
    else $error("wrong vector or no acceptance");

  AST_MASKED: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
      (pick.found && !master_enable_flag) |-> (pick.level < irq_ctrl_pkg::LEVEL_EXT0))
    else $error("maskable level picked with master flag clear");

  AST_MASTER_GATE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R7
      (pick.found && pick.level >= irq_ctrl_pkg::LEVEL_EXT0) |->
      (master_enable_flag && enable_register[pick.level]))
    else $error("maskable level picked without both enable flags");

  AST_NON_MASKABLE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R21
      (request_latch[2] && !soft_request) |->
      (pick.found && pick.level == irq_ctrl_pkg::LEVEL_TRAP))
    else $error("non-maskable latch not picked");

  AST_EXT0_GATE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R8
      (pick.found && pick.level == irq_ctrl_pkg::LEVEL_EXT0) |-> ext0_pin_enable_i)
    else $error("external 0 picked without pin enable");

  AST_TRAP_ROUTE: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R12
      (clk_en_i && ((address_trap_source_i && trap_output_select_i) ||
      (watchdog_source_i && watchdog_output_select_i))) |=> trap_reset_request_o)
    else $error("trap routed to reset raised no reset request");

  AST_ACCEPT_LENGTH: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R24
      (clk_en_i && take) |=> (cycle_count == irq_ctrl_pkg::ACCEPT_LOAD))
    else $error("acceptance count not loaded to eight machine cycles");

  AST_DONE_ENDS: assert property (@(posedge ref_clk_i) disable iff (reset_i) // R24
      accept_done_o |=> !accepting_o)
    else $error("acceptance ran past its last cycle");

  AST_RESET_CLEAR: assert property (@(posedge ref_clk_i) // R15
      reset_i |=> (request_latch == 16'h0000 && enable_register == 16'h0000))
    else $error("reset did not clear latches and enables");

endmodule : irq_latch_ctrl

// ===== rtl/irq_ctrl_pkg.sv
// Constants, types and helper functions shared by the interrupt controller files
package irq_ctrl_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
  localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
  localparam logic [7:0] ADDR_LATCH_LOW = 8'h3C;
  localparam logic [7:0] ADDR_LATCH_HIGH = 8'h3D;

  // ----------------------------------------
  // Field layout and reset values
  // ----------------------------------------
  localparam int MASTER_BIT = 0;
  localparam int FIRST_MASKABLE = 4;
  localparam logic [3:0] LEVEL_SOFT = 4'h1;
  localparam logic [3:0] LEVEL_TRAP = 4'h2;
  localparam logic [3:0] LEVEL_WATCHDOG = 4'h3;
  localparam logic [3:0] LEVEL_EXT0 = 4'h4;
  localparam logic [7:0] ENABLE_LOW_MASK = 8'hF1;
  localparam logic [7:0] LATCH_LOW_MASK = 8'hFC;
  localparam logic [15:0] LATCH_MASK = 16'hFFFC;
  localparam logic [15:0] MASKABLE_MASK = 16'hFFF0;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // Selector bit positions for the shared levels
  localparam int SEL_LEVEL8 = 0;
  localparam int SEL_LEVEL9 = 1;
  localparam int SEL_LEVEL13 = 2;
  localparam int SEL_LEVEL14 = 3;
  localparam int SEL_LEVEL15 = 4;

  // ----------------------------------------
  // Vectors and timing
  // ----------------------------------------
  localparam logic [15:0] VECTOR_RESET = 16'hFFFE;
  localparam logic [15:0] VECTOR_SOFT = 16'hFFFC;
  localparam int ACCEPT_MACHINE_CYCLES = 8;
  localparam int CLOCKS_PER_MACHINE_CYCLE = 4;
  localparam int ACCEPT_CLOCKS = ACCEPT_MACHINE_CYCLES * CLOCKS_PER_MACHINE_CYCLE;
  localparam logic [5:0] ACCEPT_LOAD = 6'(ACCEPT_CLOCKS - 1);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACCEPT = 2'b10
  } accept_state_e;

  // Level 1 stands for the two latchless sources; others step down by two
  function automatic logic [15:0] vector_of(input logic [3:0] level);
    if (level == LEVEL_SOFT) begin
      return VECTOR_SOFT;
    end
    return VECTOR_RESET - {11'h000, level, 1'b0};
  endfunction : vector_of

  function automatic logic [15:0] below_mask(input logic [3:0] level);
    return (16'h0001 << level) - 16'h0001;
  endfunction : below_mask

endpackage : irq_ctrl_pkg

// ===== rtl/irq_pick_if.sv
// Carrier between the latch logic and the priority picker
`timescale 1ns/1ps
interface irq_pick_if;
  logic [15:0] pending;
  logic found;
  logic [3:0] level;
  logic [15:0] vector;

  modport requester (output pending, input found, input level, input vector);
  modport picker (input pending, output found, output level, output vector);
endinterface : irq_pick_if

// ===== rtl/irq_priority_pick.sv
// Fixed-priority picker: lowest pending level number wins
`timescale 1ns/1ps
module irq_priority_pick (
  irq_pick_if.picker pick // Pending levels in, winner out
);

  always_comb begin
    pick.found = 1'b0;
    pick.level = 4'h0;
    // Scan downward so the lowest index is the last to be written
    for (int i = 15; i >= 1; i--) begin
      if (pick.pending[i]) begin
        pick.found = 1'b1;
        pick.level = 4'(i);
      end
    end
    pick.vector = irq_ctrl_pkg::vector_of(pick.level);
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  always_comb begin
    AST_PICK_HIGHEST: assert (!pick.found || // R4
        ((pick.pending & irq_ctrl_pkg::below_mask(pick.level)) == 16'h0000))
      else $error("picked level is not the highest pending");
  end

endmodule : irq_priority_pick

// ===== verif/cpu_boundary_model.sv
// Behavioural CPU core that offers instruction boundaries to the controller
`timescale 1ns/1ps
module cpu_boundary_model (
  input wire logic ref_clk_i, // System clock
  input wire logic reset_i, // Synchronous reset, active high
  input wire logic step_i, // Bench asks for boundaries
  input wire logic accepting_i, // Acceptance sequence running
  output logic boundary_o // Instruction boundary pulse
);
  // ----------------------------------------
  // Boundaries only when no acceptance ran in the previous cycle
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      boundary_o <= 1'b0;
    end else begin
      boundary_o <= step_i && !accepting_i;
    end
  end
endmodule : cpu_boundary_model

// ===== verif/test_prioritized_interrupt_latch_controller.sv
// Self-checking bench for the interrupt latch controller
`timescale 1ns/1ps
module test_prioritized_interrupt_latch_controller;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [4:0] sel = 5'h00;
  logic pin_en = 1'b0;
  logic trap_sel = 1'b1;
  logic wdt_sel = 1'b1;
  logic [20:0] src = 21'h000000;
  logic step = 1'b0;
  logic rfi = 1'b0;
  logic restore = 1'b0;
  logic clk_en = 1'b1;
  logic boundary, int_req, accepting, done, saved, trap_rst;
  logic [15:0] vec;
  logic [7:0] r;
  int bad_count = 0;
  int checked = 0;

  always #5 ref_clk_i = ~ref_clk_i;

  cpu_boundary_model cpu (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .step_i(step),
    .accepting_i(accepting), .boundary_o(boundary));

  irq_latch_ctrl uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata),
    .sfr_rdata_o(rdata), .shared_level_selector_i(sel), .ext0_pin_enable_i(pin_en),
    .trap_output_select_i(trap_sel), .watchdog_output_select_i(wdt_sel),
    .software_trap_source_i(src[0]), .undefined_opcode_source_i(src[1]),
    .address_trap_source_i(src[2]), .watchdog_source_i(src[3]),
    .external_request_0_i(src[4]), .external_request_1_i(src[5]),
    .external_request_2_i(src[6]), .external_request_3_i(src[7]),
    .external_request_4_i(src[8]), .external_request_5_i(src[9]),
    .timer4_source_i(src[10]), .timer5_source_i(src[11]), .time_base_source_i(src[12]),
    .timer1_source_i(src[13]), .timer3_source_i(src[14]), .timer6_source_i(src[15]),
    .timer2_source_i(src[16]), .serial1_source_i(src[17]), .receiver_source_i(src[18]),
    .converter_source_i(src[19]), .serial2_source_i(src[20]), .boundary_i(boundary),
    .return_from_interrupt_i(rfi), .restore_master_i(restore), .int_request_o(int_req),
    .accepting_o(accepting), .accept_done_o(done), .vector_o(vec),
    .saved_master_o(saved), .trap_reset_request_o(trap_rst));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop;
    if (bad_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge ref_clk_i) wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk_i) begin addr <= a; rd <= 1'b1; end
    @(posedge ref_clk_i) rd <= 1'b0;
    @(negedge ref_clk_i) d = rdata;
  endtask : rd_reg

  task automatic pulse(input int i);
    @(posedge ref_clk_i) src[i] <= 1'b1;
    @(posedge ref_clk_i) src[i] <= 1'b0;
  endtask : pulse

  // Acceptance with its vector and its length in clocks
  task automatic accept(input logic [15:0] exp_vec);
    int n;
    n = 0;
    @(posedge ref_clk_i) step <= 1'b1;
    while (accepting !== 1'b1 && n < 10) begin @(negedge ref_clk_i) n++; end
    cmp(vec, exp_vec);
    @(posedge ref_clk_i) step <= 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 100) begin @(negedge ref_clk_i) n++; end
    cmp(16'(n), 16'h0020);
    @(negedge ref_clk_i);
  endtask : accept

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_regs;
    cmp(vec, 16'hFFFE);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0000);
    rd_reg(8'h3A, r); cmp(16'(r), 16'h0000);
    wr_reg(8'h3A, 8'hFE); wr_reg(8'h3B, 8'hFF);
    rd_reg(8'h3A, r); cmp(16'(r), 16'h00F0);
    rd_reg(8'h3B, r); cmp(16'(r), 16'h00FF);
    wr_reg(8'h3C, 8'hFF); rd_reg(8'h3C, r); cmp(16'(r), 16'h0000);
    rd_reg(8'h3F, r); cmp(16'(r), 16'h0000);
    wr_reg(8'h3B, 8'h00); wr_reg(8'h3A, 8'h00);
  endtask : t_reset_and_regs

  task automatic t_shared;
    int a0[5] = '{12, 13, 17, 18, 19};
    int a1[5] = '{6, 7, 8, 9, 20};
    int lv[5] = '{8, 9, 13, 14, 15};
    for (int k = 0; k < 5; k++) begin
      sel <= 5'h00; pulse(a1[k]); pulse(a0[k]);
      rd_reg(8'h3D, r); cmp(16'(r), 16'(1 << (lv[k] - 8)));
      wr_reg(8'h3D, 8'h00);
      sel <= 5'(1 << k); pulse(a0[k]); pulse(a1[k]);
      rd_reg(8'h3D, r); cmp(16'(r), 16'(1 << (lv[k] - 8)));
      wr_reg(8'h3D, 8'h00);
    end
  endtask : t_shared

  task automatic t_freeze;
    pulse(5);
    clk_en <= 1'b0;
    pulse(11);
    wr_reg(8'h3C, 8'h0C);
    clk_en <= 1'b1;
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0020);
    wr_reg(8'h3C, 8'h0C);
  endtask : t_freeze

  task automatic t_priority;
    wr_reg(8'h3A, 8'hA0); wr_reg(8'h3A, 8'hA1);
    pulse(11); pulse(5);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h00A0);
    accept(16'hFFF4);
    cmp(16'(saved), 16'h0001);
    rd_reg(8'h3A, r); cmp(16'(r), 16'h00A0);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0080);
    cmp(16'(int_req), 16'h0000);
    @(posedge ref_clk_i) begin rfi <= 1'b1; restore <= 1'b1; end
    @(posedge ref_clk_i) rfi <= 1'b0;
    @(negedge ref_clk_i) cmp(16'(int_req), 16'h0001);
    accept(16'hFFF0);
    wr_reg(8'h3C, 8'hEF); wr_reg(8'h3C, 8'h0C);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0000);
  endtask : t_priority

  task automatic t_ext0;
    wr_reg(8'h3A, 8'h10); wr_reg(8'h3A, 8'h11);
    pin_en <= 1'b0; pulse(4);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0010);
    cmp(16'(int_req), 16'h0000);
    @(posedge ref_clk_i) pin_en <= 1'b1;
    accept(16'hFFF6);
    wr_reg(8'h3A, 8'h00);
  endtask : t_ext0

  task automatic t_nonmaskable;
    pulse(2);
    @(negedge ref_clk_i) cmp(16'(trap_rst), 16'h0001);
    pulse(3);
    @(negedge ref_clk_i) cmp(16'(trap_rst), 16'h0001);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h0000);
    @(posedge ref_clk_i) begin trap_sel <= 1'b0; wdt_sel <= 1'b0; end
    pulse(2); pulse(3);
    rd_reg(8'h3C, r); cmp(16'(r), 16'h000C);
    accept(16'hFFFA);
    accept(16'hFFF8);
    @(posedge ref_clk_i) src[0] <= 1'b1;
    accept(16'hFFFC);
    @(posedge ref_clk_i) src[0] <= 1'b0;
    @(posedge ref_clk_i) src[1] <= 1'b1;
    accept(16'hFFFC);
    @(posedge ref_clk_i) src[1] <= 1'b0;
  endtask : t_nonmaskable

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    t_reset_and_regs;
    t_shared;
    t_freeze;
    t_priority;
    t_ext0;
    t_nonmaskable;
    report_and_stop;
  end

  initial begin
    #200000;
    bad_count++;
    report_and_stop;
  end
endmodule : test_prioritized_interrupt_latch_controller
